/* hw/rld_pkg.sv */
package rld_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [11:0] RLD_OFS_CTRL0 = 12'h000;
    localparam logic [11:0] RLD_OFS_CTRL1 = 12'h004;
    localparam logic [11:0] RLD_OFS_STAT  = 12'h008;
    localparam int          RLD_AW        = 12;

    // ------------------------------------------------------------------
    // Field positions of control register 0
    // ------------------------------------------------------------------
    localparam int RLD_BIT_EN   = 7;
    localparam int RLD_BIT_LPS  = 6;
    localparam int RLD_BIT_OE   = 5;
    localparam int RLD_BIT_PSLO = 2;
    localparam int RLD_BIT_PSHI = 3;
    localparam int RLD_BIT_NSS  = 0;
    localparam int RLD_LVL_W    = 5;
    localparam int RLD_LEVELS   = 32;

    // ------------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RLD_CTRL0_RST  = 8'h00;
    localparam logic [7:0] RLD_CTRL0_MASK = 8'hED;
    localparam logic [4:0] RLD_LVL_RST    = 5'h00;
    localparam logic [4:0] RLD_LVL_FULL   = 5'h1F;

    // Positive source codes, code 3 reserved (acts as supply)
    typedef enum logic [1:0] {
        RLD_PSRC_SUPPLY = 2'h0,
        RLD_PSRC_EXTREF = 2'h1,
        RLD_PSRC_FIXREF = 2'h2,
        RLD_PSRC_RSVD   = 2'h3
    } rld_psrc_e;

    // One-hot source switch selects
    localparam logic [2:0] RLD_PSW_SUPPLY = 3'h1;
    localparam logic [2:0] RLD_PSW_EXTREF = 3'h2;
    localparam logic [2:0] RLD_PSW_FIXREF = 3'h4;
    localparam logic [1:0] RLD_NSW_GND    = 2'h1;
    localparam logic [1:0] RLD_NSW_EXTREF = 2'h2;

    // Bus phase tracker states
    typedef enum logic [1:0] {
        RLD_ST_IDLE = 2'h1,
        RLD_ST_DATA = 2'h2
    } rld_state_e;

    // Control to the analog ladder
    typedef struct packed {
        logic       enable;
        logic       lowPower;
        logic       pinOut;
        rld_psrc_e  posSel;
        logic       negSel;
        logic [4:0] level;
    } rld_ctrl_s;

    // Ladder switch drive
    typedef struct packed {
        logic [31:0] tap;
        logic [2:0]  posSwitch;
        logic [1:0]  negSwitch;
        logic        posConnect;
        logic        negConnect;
    } rld_ladder_s;

endpackage

/* hw/rld_ladder_decode.sv */
module rld_ladder_decode
    import rld_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire rld_ctrl_s   ctrl,
    output rld_ladder_s      ladder
);

    // ------------------------------------------------------------------
    // Tap decode and source switches
    // ------------------------------------------------------------------
    logic [RLD_LEVELS-1:0] tapNxt;
    logic [2:0]            posSw;
    logic [1:0]            negSw;
    rld_ladder_s           ladder_r;

    // One tap per level; tap 0 sits on the negative source
    genvar gi;
    generate
        for (gi = 0; gi < RLD_LEVELS; gi++) begin : g_tap
            assign tapNxt[gi] = (ctrl.level == RLD_LVL_W'(gi)); // [RL1] [RL2]
        end
    endgenerate

    // Reserved code falls back to the supply, safest rail
    assign posSw = (ctrl.posSel == RLD_PSRC_EXTREF) ? RLD_PSW_EXTREF :
                   (ctrl.posSel == RLD_PSRC_FIXREF) ? RLD_PSW_FIXREF :
                   RLD_PSW_SUPPLY;                              // [RL3] [RL15]
    assign negSw = ctrl.negSel ? RLD_NSW_EXTREF : RLD_NSW_GND;  // [RL3] [RL9]

    // Registered so the switches never glitch on decode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ladder_r <= '0;
        end else begin
            ladder_r.tap        <= tapNxt;
            ladder_r.posSwitch  <= posSw;
            ladder_r.negSwitch  <= negSw;
            // While disabled one rail is cut, picked by low power; enabled ladder keeps both
            ladder_r.posConnect <= ctrl.enable | ctrl.lowPower; // [RL6]
            ladder_r.negConnect <= ctrl.enable | ~ctrl.lowPower; // [RL6]
        end
    end

    assign ladder = ladder_r;

endmodule // rld_ladder_decode

/* hw/rld_ctrl.sv */
// Notes on behaviour
// [RL1] 32 output levels chosen by 5-bit level field in control register 1
// [RL2] Output is negative source plus difference times code over 32
// [RL3] Positive source: fixed ref, supply, ext pin; negative: ground or pin
// [RL4] Pin output enable routes output to pin, overriding digital driver/input
// [RL5] Digital read of the pin returns zero while routed to converter
// [RL6] Low-power bit 6 cuts negative source when set, positive when clear
// [RL7] Software clamps high: disable, low-power set, pick source, code 11111
// [RL8] Software clamps low: disable, low-power clear, code 00000
// [RL9] Negative select picks external pin when 1, ground when 0
// [RL10] Wake from sleep leaves control register 0 unchanged
// [RL11] Software should disable the converter before sleep
// [RL12] Reset disables converter and removes output from the pin
// [RL13] Reset clears the level field to zero
// [RL14] Enable at bit 7 of control register 0
// [RL15] Two-bit positive select maps to supply, ext ref, fixed ref, one spare
// [RL16] Controls are registered outputs updated the cycle after a write
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
module rld_ctrl
    import rld_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Pin side
    input  wire logic        pinDigitalIn,
    output logic             pinDigitalRead,
    output logic             pinDriverOverride,
    output logic             pinInputOverride,
    // Analog ladder side
    output rld_ctrl_s        ladderCtrl,
    output rld_ladder_s      ladderDrive
);

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    rld_state_e        state_r;
    rld_state_e        state_nxt;
    logic [RLD_AW-1:0] addr_r;
    logic              write_r;
    logic              addrPhase;

    assign addrPhase = hsel & htrans[1] & hready;

    // Data phase follows every accepted address phase
    assign state_nxt = addrPhase ? RLD_ST_DATA : RLD_ST_IDLE;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= RLD_ST_IDLE;
            addr_r  <= '0;
            write_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (addrPhase) begin
                addr_r  <= haddr[RLD_AW-1:0];
                write_r <= hwrite;
            end
        end
    end

    // Zero wait states, never an error
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic inData;
    logic selCtrl0;
    logic selCtrl1;
    logic selStat;
    logic wrCtrl0;
    logic wrCtrl1;

    assign inData = (state_r == RLD_ST_DATA);
    always_comb begin
        selCtrl0 = 1'b0;
        selCtrl1 = 1'b0;
        selStat  = 1'b0;
        if (addr_r == RLD_OFS_CTRL0) begin
            selCtrl0 = 1'b1;
        end else if (addr_r == RLD_OFS_CTRL1) begin
            selCtrl1 = 1'b1;
        end else if (addr_r == RLD_OFS_STAT) begin
            selStat = 1'b1;
        end
    end
    assign wrCtrl0 = inData & write_r & selCtrl0;
    assign wrCtrl1 = inData & write_r & selCtrl1;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0]           ctrl0_r;
    logic [RLD_LVL_W-1:0] level_r;

    // Only reset and bus writes touch these; sleep/wake has no path here [RL10]
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl0_r <= RLD_CTRL0_RST;   // [RL12]
            level_r <= RLD_LVL_RST;     // [RL13]
        end else begin
            if (wrCtrl0) begin
                ctrl0_r <= hwdata[7:0] & RLD_CTRL0_MASK; // [RL14]
            end
            if (wrCtrl1) begin
                level_r <= hwdata[RLD_LVL_W-1:0];        // [RL1]
            end
        end
    end

    // Field view of the stored bits
    rld_ctrl_s ctrlNow;
    assign ctrlNow.enable   = ctrl0_r[RLD_BIT_EN];      // [RL14]
    assign ctrlNow.lowPower = ctrl0_r[RLD_BIT_LPS];     // [RL6]
    assign ctrlNow.pinOut   = ctrl0_r[RLD_BIT_OE];      // [RL4]
    assign ctrlNow.posSel   =
        rld_psrc_e'(ctrl0_r[RLD_BIT_PSHI:RLD_BIT_PSLO]); // [RL15]
    assign ctrlNow.negSel   = ctrl0_r[RLD_BIT_NSS];     // [RL9]
    assign ctrlNow.level    = level_r;                  // [RL2]

    // Output copy lands one cycle after the write's data phase
    rld_ctrl_s ctrlOut_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrlOut_r <= '0;
        end else begin
            ctrlOut_r <= ctrlNow;  // [RL16]
        end
    end
    assign ladderCtrl = ctrlOut_r;

    // ------------------------------------------------------------------
    // Ladder switch decode
    // ------------------------------------------------------------------
    rld_ladder_decode u_decode (
        .mclk   (mclk),
        .rst    (rst),
        .ctrl   (ctrlNow),
        .ladder (ladderDrive)
    );

    // ------------------------------------------------------------------
    // Pin override and digital read path
    // ------------------------------------------------------------------
    logic pinSync1_r;
    logic pinSync2_r;
    logic pinRead_r;

    // Pin is asynchronous to mclk, two stages before use
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinSync1_r <= 1'b0;
            pinSync2_r <= 1'b0;
            pinRead_r  <= 1'b0;
        end else begin
            pinSync1_r <= pinDigitalIn;
            pinSync2_r <= pinSync1_r;
            // Analog level must never leak in as a digital value
            pinRead_r  <= pinSync2_r & ~ctrlNow.pinOut; // [RL5]
        end
    end

    assign pinDigitalRead    = pinRead_r;
    assign pinDriverOverride = ctrlOut_r.pinOut; // [RL4] [RL12]
    assign pinInputOverride  = ctrlOut_r.pinOut; // [RL4]

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rdMux;
    assign rdMux = selCtrl0 ? {24'h000000, ctrl0_r} :
                   selCtrl1 ? {27'h0000000, level_r} :
                   selStat  ? {31'h00000000, pinRead_r} :
                   32'h00000000;
    assign hrdata = (inData & ~write_r) ? rdMux : 32'h00000000;

endmodule // rld_ctrl

/* dv/rld_ctrl_checker.sv */
module rld_ctrl_checker
    import rld_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pinDigitalRead,
    input wire logic        pinDriverOverride,
    input wire logic        pinInputOverride,
    input wire rld_ctrl_s   ladderCtrl,
    input wire rld_ladder_s ladderDrive
);
    // ------------
    // Checks
    // ------------
    logic settled_r;
    // Switch drive is zero in reset, valid one edge later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) settled_r <= 1'b0;
        else settled_r <= 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence wrSeq(logic [11:0] a);
        hsel && htrans[1] && hready && hwrite && haddr[11:0] == a;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    ctrl_write_a: assert property (wrSeq(RLD_OFS_CTRL0) |-> ##3
        ladderCtrl[10:5] == $past({hwdata[7:5], hwdata[3:2], hwdata[0]}, 2))
        else $error("ladder controls differ from written word");
    level_write_a: assert property (wrSeq(RLD_OFS_CTRL1) |-> ##3
        ladderCtrl.level == $past(hwdata[4:0], 2))
        else $error("level differs from written word");
    tap_onehot_a: assert property (settled_r |->
        ladderDrive.tap == 32'h1 << ladderCtrl.level)
        else $error("tap is not the level code");
    pos_switch_a: assert property (settled_r |->
        ladderDrive.posSwitch ==
        (ladderCtrl.posSel == RLD_PSRC_EXTREF ? RLD_PSW_EXTREF :
         ladderCtrl.posSel == RLD_PSRC_FIXREF ? RLD_PSW_FIXREF :
         RLD_PSW_SUPPLY))
        else $error("positive switch wrong");
    neg_switch_a: assert property (settled_r |->
        ladderDrive.negSwitch ==
        (ladderCtrl.negSel ? RLD_NSW_EXTREF : RLD_NSW_GND))
        else $error("negative switch wrong");
    rail_connect_a: assert property (settled_r |->
        {ladderDrive.posConnect, ladderDrive.negConnect} ==
        {ladderCtrl.enable | ladderCtrl.lowPower,
         ladderCtrl.enable | !ladderCtrl.lowPower})
        else $error("rail connect wrong");
    pin_override_a: assert property (
        {pinDriverOverride, pinInputOverride} == {2{ladderCtrl.pinOut}})
        else $error("pin overrides differ from enable");
    pin_read_zero_a: assert property (pinDriverOverride [*2]
        |-> !pinDigitalRead)
        else $error("pin read not zero while routed");
    reset_clear_a: assert property (disable iff (1'b0) rst |->
        !ladderCtrl.enable && !pinDriverOverride && ladderCtrl.level == 5'h00)
        else $error("reset did not clear controls");
endmodule // rld_ctrl_checker

bind rld_ctrl rld_ctrl_checker i_chk (.mclk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hreadyout, .hresp, .pinDigitalRead,
    .pinDriverOverride, .pinInputOverride, .ladderCtrl, .ladderDrive);

/* dv/rld_ctrl_test.sv */
module rld_ctrl_test
    import rld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rst, hsel, hwrite, hready, hreadyout, hresp, pinDigitalIn;
    logic        pinDigitalRead, pinDriverOverride, pinInputOverride;
    logic [31:0] haddr, hwdata, hrdata, rdq, seed, d, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    rld_ctrl_s   ladderCtrl;
    rld_ladder_s ladderDrive;
    int          fails, samplesChecked;

    // ------------
    // Clock, bus wiring, design
    // ------------
    always #5 mclk = ~mclk;
    assign hready = hreadyout;
    // Read data latched mid-cycle, so the closing edge cannot race it
    always @(negedge mclk) rdq = hrdata;
    rld_ctrl i_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pinDigitalIn,
        .pinDigitalRead, .pinDriverOverride, .pinInputOverride, .ladderCtrl,
        .ladderDrive);

    // ------------
    // Helpers
    // ------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        samplesChecked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        $display("checked %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            summarize();
        end
    endtask
    // One single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        waitRdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitRdy();
        rd = rdq;
    endtask

    // ------------
    // Main sequence
    // ------------
    initial begin
        // Reset raised by NBA so the design's async reset sees the edge
        {hsel, hwrite, pinDigitalIn} = 3'h0;
        rst <= 1'b1;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {fails, samplesChecked} = 0;
        seed = 32'h1d2f;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        bus(0, RLD_OFS_CTRL0, 0, v);
        chk("ctrl0 reset", 0, v);
        bus(0, RLD_OFS_CTRL1, 0, v);
        chk("ctrl1 reset", 0, v);
        $display("done reset values");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            d = {seed[31:4], i[1:0], seed[1:0]};
            bus(1, RLD_OFS_CTRL0, d, v);
            bus(0, RLD_OFS_CTRL0, 0, v);
            chk("ctrl0", {24'h0, d[7:0] & RLD_CTRL0_MASK}, v);
            chk("ladder", {d[7:5], d[3:2], d[0]}, ladderCtrl[10:5]);
        end
        $display("done control word");
        for (int i = 0; i < RLD_LEVELS; i++) begin
            seed = lfsr(seed);
            bus(1, RLD_OFS_CTRL1, {seed[31:5], i[4:0]}, v);
            bus(0, RLD_OFS_CTRL1, 0, v);
            chk("level", i, v);
            chk("tap", 32'h1 << i, ladderDrive.tap);
        end
        $display("done levels");
        pinDigitalIn <= 1'b1;
        bus(1, RLD_OFS_CTRL0, 32'h20, v);
        bus(0, RLD_OFS_STAT, 0, v);
        chk("pin routed", 3'h3,
            {v[0], pinDriverOverride, pinInputOverride});
        bus(1, RLD_OFS_CTRL0, 0, v);
        repeat (4) @(posedge mclk);
        bus(0, RLD_OFS_STAT, 0, v);
        chk("pin free", 3'h4,
            {v[0], pinDriverOverride, pinInputOverride});
        bus(1, 12'h00C, 32'hFFFF_FFFF, v);
        bus(0, 12'h00C, 0, v);
        chk("unmapped", 0, v);
        $display("done pin and unmapped");
        bus(1, RLD_OFS_CTRL0, 32'h48, v);
        bus(1, RLD_OFS_CTRL1, 32'h1F, v);
        repeat (2) @(posedge mclk);
        chk("clamp high", 7'h5F, {ladderDrive.posConnect,
            ladderDrive.negConnect, ladderCtrl.level});
        bus(1, RLD_OFS_CTRL0, 32'h01, v);
        bus(1, RLD_OFS_CTRL1, 32'h00, v);
        repeat (2) @(posedge mclk);
        chk("clamp low", 9'h0C0, {ladderDrive.posConnect,
            ladderDrive.negConnect, ladderDrive.negSwitch, ladderCtrl.level});
        $display("done clamps");
        bus(1, RLD_OFS_CTRL0, 32'hED, v);
        bus(1, RLD_OFS_CTRL1, 32'h1F, v);
        repeat (2) @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        bus(0, RLD_OFS_CTRL1, 0, v);
        chk("level after reset", 0, v);
        chk("after reset", 0, {ladderCtrl.enable, pinDriverOverride});
        $display("done mid-run reset");
        summarize();
    end
endmodule // rld_ctrl_test
